// >>> rtl/arc_cfg.svh
// Constants of the alarm relay comparator: offsets, fields, interrupt bits, timing.
// Assumes inclusion by the package, the top module and the bench.
// Functional notes
// - Two or four alarm channels, one relay each, count fixed by option.
// - Each channel has an enable; a disabled channel never energizes its relay.
// - High mode energizes when the value rises above the setpoint.
// - Low mode energizes when the value falls below the setpoint.
// - Low mode releases only above setpoint plus up-hysteresis.
// - High mode releases only below setpoint minus down-hysteresis.
// - Energizing waits a programmable on-delay after the trip condition.
// - Release waits a programmable off-delay after the release condition.
// - Status reports per channel enable and relay energized.
// - Logging failure flag on card absent, card full or hardware fault.
// - Sensor wiring flag on open, shorted or damaged connection.
// - Over-range flag when value is outside the sensor range.
// - Output-span flag when value is beyond the current output span.
// - Percent of range: range minimum is zero, maximum is full scale.
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH
`define ARC_CLK_HZ        25000000
`define ARC_TICK_MS       1
`define ARC_TICK_CYC      ((`ARC_CLK_HZ / 1000) * `ARC_TICK_MS)
`define ARC_PCT_FULL      100
// Global register byte addresses
`define ARC_A_CTRL        8'h00
`define ARC_A_RANGE_MIN   8'h04
`define ARC_A_RANGE_MAX   8'h08
`define ARC_A_SPAN_MIN    8'h0C
`define ARC_A_SPAN_MAX    8'h10
`define ARC_A_CHSTAT      8'h14
`define ARC_A_FLAGS       8'h18
`define ARC_A_IRQ_STAT    8'h1C
`define ARC_A_IRQ_MASK    8'h20
`define ARC_A_PERCENT     8'h24
`define ARC_A_VALUE       8'h28
// Per channel block: base + 16 * channel
`define ARC_A_CH_BASE     8'h40
`define ARC_CH_STRIDE_SH  4
`define ARC_CH_SETPT      2'h0
`define ARC_CH_HYST       2'h1
`define ARC_CH_DELAY      2'h2
`define ARC_CH_CFG        2'h3
// Channel config fields
`define ARC_CFG_EN_BIT    0
`define ARC_CFG_HIGH_BIT  1
// Interrupt status bit positions
`define ARC_IRQ_E1        0
`define ARC_IRQ_E2        1
`define ARC_IRQ_E3        2
`define ARC_IRQ_E4        3
`define ARC_IRQ_RLY       4
`define ARC_IRQ_W         8
`endif

// >>> rtl/arc_pkg.sv
// Types of the alarm relay comparator.
// Assumes arc_cfg.svh sits beside it.
`include "arc_cfg.svh"
package arc_pkg;
   typedef enum logic [1:0] {
      ARC_IDLE    = 2'b00,
      ARC_ON_WAIT = 2'b01,
      ARC_ACTIVE  = 2'b10,
      ARC_OFF_WAIT= 2'b11
   } arc_ch_state_t;

   typedef struct packed {
      logic        en;
      logic        high_mode;
      logic [15:0] setpt;
      logic [15:0] hyst_up;
      logic [15:0] hyst_dn;
      logic [15:0] dly_on;
      logic [15:0] dly_off;
   } arc_ch_cfg_t;

   typedef struct packed {
      arc_ch_state_t st;
      logic [15:0]   cnt;
      logic          relay;
   } arc_ch_run_t;

   typedef struct packed {
      logic card_absent;
      logic card_full;
      logic log_hw_fault;
      logic wire_open;
      logic wire_short;
      logic wire_damage;
   } arc_fault_in_t;
endpackage

// >>> rtl/arc_top.sv
// Alarm relay comparator: per channel threshold, hysteresis and delays, error flags,
// percent of range, register port and interrupt.
// Assumes a signed measurement word from the front end, pin level fault inputs.
//
// Design decisions made here: strobed register access and the address map.
`include "arc_cfg.svh"
module arc_top #(
   parameter int NUM_CH   = 4,
   parameter int TICK_CYC = `ARC_TICK_CYC
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic signed [15:0]   meas_value,
   input  wire logic                 meas_valid,
   input  wire arc_pkg::arc_fault_in_t fault_pins,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   output logic [NUM_CH-1:0]         relay_out,
   output logic [NUM_CH-1:0]         alarm_enabled,
   output logic                      logging_failure_flag,
   output logic                      sensor_wiring_fault_flag,
   output logic                      over_range_flag,
   output logic                      output_span_exceeded_flag,
   output logic [6:0]                percent_range,
   output logic                      irq
);
   localparam int NCH = (NUM_CH > 2) ? 4 : 2;
   localparam int TW  = $clog2(TICK_CYC + 1);

   typedef struct packed {
      arc_pkg::arc_fault_in_t       f_s1;
      arc_pkg::arc_fault_in_t       f_s2;
      logic signed [15:0]           val;
      logic [TW-1:0]                tick_cnt;
      logic                         tick;
      arc_pkg::arc_ch_cfg_t [NCH-1:0] cfg;
      arc_pkg::arc_ch_run_t [NCH-1:0] run;
      logic signed [15:0]           rng_min;
      logic signed [15:0]           rng_max;
      logic signed [15:0]           spn_min;
      logic signed [15:0]           spn_max;
      logic [3:0]                   flags;
      logic [6:0]                   pct;
      logic [`ARC_IRQ_W-1:0]        ist;
      logic [`ARC_IRQ_W-1:0]        imask;
      logic [31:0]                  rdata;
      logic                         irq;
   } arc_state_t;

   arc_state_t s_reg;
   arc_state_t s_next;

   function automatic logic [31:0] ch_read(input arc_pkg::arc_ch_cfg_t c, input logic [1:0] f);
      logic [31:0] r;
      r = 32'h0;
      if (f == `ARC_CH_SETPT) r = {16'h0, c.setpt};
      else if (f == `ARC_CH_HYST) r = {c.hyst_dn, c.hyst_up};
      else if (f == `ARC_CH_DELAY) r = {c.dly_off, c.dly_on};
      else r = {30'h0, c.high_mode, c.en};
      return r;
   endfunction

   logic               in_ch_space;
   logic [1:0]         ch_idx;
   logic [1:0]         ch_fld;
   logic               fl_e1, fl_e2, fl_e3, fl_e4;
   logic [NCH-1:0]     rly_rise;
   logic [31:0]        num;
   logic [31:0]        den;

   always_comb begin
      s_next = s_reg;
      in_ch_space = (reg_addr >= `ARC_A_CH_BASE) &&
                    (reg_addr < (`ARC_A_CH_BASE + 8'(NCH << `ARC_CH_STRIDE_SH)));
      ch_idx = reg_addr[5:4];
      ch_fld = reg_addr[3:2];
      rly_rise = '0;
      num = 32'h0;
      den = 32'h1;
      // Fault pins pass two flops before use
      s_next.f_s1 = fault_pins;
      s_next.f_s2 = s_reg.f_s1;
      if (meas_valid) begin
         s_next.val = meas_value;
      end
      // Millisecond tick for the delays
      if (s_reg.tick_cnt == TW'(TICK_CYC - 1)) begin
         s_next.tick_cnt = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.tick_cnt = s_reg.tick_cnt + TW'(1);
         s_next.tick = 1'b0;
      end
      // Channel comparators; each uses only its own settings
      for (int i = 0; i < NCH; i++) begin
         logic trip;
         logic rel;
         arc_pkg::arc_ch_cfg_t c;
         trip = 1'b0;
         rel = 1'b0;
         c = s_reg.cfg[i];
         if (c.high_mode) begin
            trip = s_reg.val > $signed(c.setpt);
            rel = 18'(s_reg.val) < (18'($signed(c.setpt)) - 18'($signed({1'b0, c.hyst_dn})));
         end else begin
            trip = s_reg.val < $signed(c.setpt);
            rel = 18'(s_reg.val) > (18'($signed(c.setpt)) + 18'($signed({1'b0, c.hyst_up})));
         end
         case (s_reg.run[i].st)
            arc_pkg::ARC_IDLE: begin
               if (trip) begin
                  s_next.run[i].st = arc_pkg::ARC_ON_WAIT;
                  s_next.run[i].cnt = c.dly_on;
               end
            end
            arc_pkg::ARC_ON_WAIT: begin
               if (!trip) begin
                  s_next.run[i].st = arc_pkg::ARC_IDLE;
               end else if (s_reg.run[i].cnt == 16'h0) begin
                  s_next.run[i].st = arc_pkg::ARC_ACTIVE;
                  s_next.run[i].relay = 1'b1;
                  rly_rise[i] = 1'b1;
               end else if (s_reg.tick) begin
                  s_next.run[i].cnt = s_reg.run[i].cnt - 16'h1;
               end
            end
            arc_pkg::ARC_ACTIVE: begin
               if (rel) begin
                  s_next.run[i].st = arc_pkg::ARC_OFF_WAIT;
                  s_next.run[i].cnt = c.dly_off;
               end
            end
            default: begin
               if (!rel) begin
                  s_next.run[i].st = arc_pkg::ARC_ACTIVE;
               end else if (s_reg.run[i].cnt == 16'h0) begin
                  s_next.run[i].st = arc_pkg::ARC_IDLE;
                  s_next.run[i].relay = 1'b0;
               end else if (s_reg.tick) begin
                  s_next.run[i].cnt = s_reg.run[i].cnt - 16'h1;
               end
            end
         endcase
         if (!c.en) begin
            s_next.run[i].st = arc_pkg::ARC_IDLE;
            s_next.run[i].relay = 1'b0;
            rly_rise[i] = 1'b0;
         end
      end
      // Error flags
      fl_e1 = s_reg.f_s2.card_absent | s_reg.f_s2.card_full | s_reg.f_s2.log_hw_fault;
      fl_e2 = s_reg.f_s2.wire_open | s_reg.f_s2.wire_short | s_reg.f_s2.wire_damage;
      fl_e3 = (s_reg.val < s_reg.rng_min) || (s_reg.val > s_reg.rng_max);
      fl_e4 = (s_reg.val < s_reg.spn_min) || (s_reg.val > s_reg.spn_max);
      s_next.flags = {fl_e4, fl_e3, fl_e2, fl_e1};
      // Percent of range, clamped at both ends
      if (s_reg.val <= s_reg.rng_min || s_reg.rng_max <= s_reg.rng_min) begin
         s_next.pct = 7'h0;
      end else if (s_reg.val >= s_reg.rng_max) begin
         s_next.pct = 7'(`ARC_PCT_FULL);
      end else begin
         num = 32'(17'(s_reg.val) - 17'(s_reg.rng_min)) * 32'(`ARC_PCT_FULL);
         den = 32'(17'(s_reg.rng_max) - 17'(s_reg.rng_min));
         s_next.pct = 7'(num / den);
      end
      // Register read, data one cycle later
      s_next.rdata = 32'h0;
      if (reg_rd) begin
         if (reg_addr == `ARC_A_CTRL) s_next.rdata = 32'(NCH);
         else if (reg_addr == `ARC_A_RANGE_MIN) s_next.rdata = 32'(s_reg.rng_min);
         else if (reg_addr == `ARC_A_RANGE_MAX) s_next.rdata = 32'(s_reg.rng_max);
         else if (reg_addr == `ARC_A_SPAN_MIN) s_next.rdata = 32'(s_reg.spn_min);
         else if (reg_addr == `ARC_A_SPAN_MAX) s_next.rdata = 32'(s_reg.spn_max);
         else if (reg_addr == `ARC_A_CHSTAT) begin
            for (int i = 0; i < NCH; i++) begin
               s_next.rdata[i] = s_reg.cfg[i].en;
               s_next.rdata[8 + i] = s_reg.run[i].relay;
            end
         end
         else if (reg_addr == `ARC_A_FLAGS) s_next.rdata = {28'h0, s_reg.flags};
         else if (reg_addr == `ARC_A_IRQ_STAT) s_next.rdata = 32'(s_reg.ist);
         else if (reg_addr == `ARC_A_IRQ_MASK) s_next.rdata = 32'(s_reg.imask);
         else if (reg_addr == `ARC_A_PERCENT) s_next.rdata = 32'(s_reg.pct);
         else if (reg_addr == `ARC_A_VALUE) s_next.rdata = 32'(s_reg.val);
         else if (in_ch_space) s_next.rdata = ch_read(s_reg.cfg[ch_idx], ch_fld);
      end
      // Register write
      if (reg_wr) begin
         if (reg_addr == `ARC_A_RANGE_MIN) s_next.rng_min = reg_wdata[15:0];
         else if (reg_addr == `ARC_A_RANGE_MAX) s_next.rng_max = reg_wdata[15:0];
         else if (reg_addr == `ARC_A_SPAN_MIN) s_next.spn_min = reg_wdata[15:0];
         else if (reg_addr == `ARC_A_SPAN_MAX) s_next.spn_max = reg_wdata[15:0];
         else if (reg_addr == `ARC_A_IRQ_STAT) s_next.ist = s_reg.ist & ~reg_wdata[7:0];
         else if (reg_addr == `ARC_A_IRQ_MASK) s_next.imask = reg_wdata[7:0];
         else if (in_ch_space) begin
            if (ch_fld == `ARC_CH_SETPT) s_next.cfg[ch_idx].setpt = reg_wdata[15:0];
            else if (ch_fld == `ARC_CH_HYST) begin
               s_next.cfg[ch_idx].hyst_up = reg_wdata[15:0];
               s_next.cfg[ch_idx].hyst_dn = reg_wdata[31:16];
            end else if (ch_fld == `ARC_CH_DELAY) begin
               s_next.cfg[ch_idx].dly_on = reg_wdata[15:0];
               s_next.cfg[ch_idx].dly_off = reg_wdata[31:16];
            end else begin
               s_next.cfg[ch_idx].en = reg_wdata[`ARC_CFG_EN_BIT];
               s_next.cfg[ch_idx].high_mode = reg_wdata[`ARC_CFG_HIGH_BIT];
            end
         end
      end
      // Sticky events: set wins over a clear in the same cycle
      s_next.ist[`ARC_IRQ_E1] = s_next.ist[`ARC_IRQ_E1] | (fl_e1 & ~s_reg.flags[0]);
      s_next.ist[`ARC_IRQ_E2] = s_next.ist[`ARC_IRQ_E2] | (fl_e2 & ~s_reg.flags[1]);
      s_next.ist[`ARC_IRQ_E3] = s_next.ist[`ARC_IRQ_E3] | (fl_e3 & ~s_reg.flags[2]);
      s_next.ist[`ARC_IRQ_E4] = s_next.ist[`ARC_IRQ_E4] | (fl_e4 & ~s_reg.flags[3]);
      s_next.ist[`ARC_IRQ_RLY] = s_next.ist[`ARC_IRQ_RLY] | (|rly_rise);
      s_next.irq = |(s_next.ist & s_next.imask);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         relay_out[i] = (i < NCH) ? s_reg.run[i % NCH].relay : 1'b0;
         alarm_enabled[i] = (i < NCH) ? s_reg.cfg[i % NCH].en : 1'b0;
      end
   end
   assign reg_rdata = s_reg.rdata;
   assign logging_failure_flag = s_reg.flags[0];
   assign sensor_wiring_fault_flag = s_reg.flags[1];
   assign over_range_flag = s_reg.flags[2];
   assign output_span_exceeded_flag = s_reg.flags[3];
   assign percent_range = s_reg.pct;
   assign irq = s_reg.irq;

   // Checks
   for (genvar g = 0; g < NCH; g++) begin : g_chk
      a_disabled_no_relay: assert property (@(posedge sys_clk) disable iff (!rstn)
         !s_reg.cfg[g].en |=> !s_reg.run[g].relay)
         else $error("disabled channel has relay on");
      a_on_needs_trip: assert property (@(posedge sys_clk) disable iff (!rstn)
         $rose(s_reg.run[g].relay) |-> $past(s_reg.run[g].st) == arc_pkg::ARC_ON_WAIT)
         else $error("relay energized without on-delay");
      a_off_needs_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
         $fell(s_reg.run[g].relay) && $past(s_reg.cfg[g].en)
         |-> $past(s_reg.run[g].st) == arc_pkg::ARC_OFF_WAIT)
         else $error("relay released without off-delay");
      a_high_trip: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.cfg[g].en && s_reg.cfg[g].high_mode && s_reg.run[g].st == arc_pkg::ARC_IDLE
         && s_reg.val > $signed(s_reg.cfg[g].setpt) && $stable(s_reg.cfg[g])
         |=> s_reg.run[g].st == arc_pkg::ARC_ON_WAIT)
         else $error("high mode trip missed");
      a_low_trip: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.cfg[g].en && !s_reg.cfg[g].high_mode && s_reg.run[g].st == arc_pkg::ARC_IDLE
         && s_reg.val < $signed(s_reg.cfg[g].setpt)
         |=> s_reg.run[g].st == arc_pkg::ARC_ON_WAIT)
         else $error("low mode trip missed");
      a_disabled_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
         !s_reg.cfg[g].en |=> s_reg.run[g].st == arc_pkg::ARC_IDLE)
         else $error("disabled channel not idle");
      a_on_count: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.run[g].st == arc_pkg::ARC_ON_WAIT && s_reg.run[g].cnt != 16'h0
         |=> !s_reg.run[g].relay)
         else $error("relay on before on-delay end");
      a_off_count: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.cfg[g].en && s_reg.run[g].st == arc_pkg::ARC_OFF_WAIT
         && s_reg.run[g].cnt != 16'h0 |=> s_reg.run[g].relay)
         else $error("relay off before off-delay end");
      a_low_release: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.cfg[g].en && !s_reg.cfg[g].high_mode && s_reg.run[g].st == arc_pkg::ARC_ACTIVE
         && 18'(s_reg.val) > 18'($signed(s_reg.cfg[g].setpt))
            + 18'($signed({1'b0, s_reg.cfg[g].hyst_up}))
         |=> s_reg.run[g].st == arc_pkg::ARC_OFF_WAIT)
         else $error("low mode release missed");
      a_high_release: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.cfg[g].en && s_reg.cfg[g].high_mode && s_reg.run[g].st == arc_pkg::ARC_ACTIVE
         && 18'(s_reg.val) < 18'($signed(s_reg.cfg[g].setpt))
            - 18'($signed({1'b0, s_reg.cfg[g].hyst_dn}))
         |=> s_reg.run[g].st == arc_pkg::ARC_OFF_WAIT)
         else $error("high mode release missed");
      a_on_lapse: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.cfg[g].en && s_reg.run[g].st == arc_pkg::ARC_ON_WAIT
         && (s_reg.cfg[g].high_mode ? s_reg.val <= $signed(s_reg.cfg[g].setpt)
                                    : s_reg.val >= $signed(s_reg.cfg[g].setpt))
         |=> s_reg.run[g].st == arc_pkg::ARC_IDLE)
         else $error("lapsed trip kept waiting");
      a_relay_state: assert property (@(posedge sys_clk) disable iff (!rstn)
         s_reg.run[g].relay == (s_reg.run[g].st == arc_pkg::ARC_ACTIVE
                                || s_reg.run[g].st == arc_pkg::ARC_OFF_WAIT))
         else $error("relay differs from state");
   end
   a_status_relay: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == `ARC_A_CHSTAT |=> reg_rdata[8] == $past(s_reg.run[0].relay))
      else $error("status relay bit wrong");
   a_wire_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
      fault_pins.wire_open ##1 fault_pins.wire_open ##1 fault_pins.wire_open
      |=> sensor_wiring_fault_flag)
      else $error("wiring flag not raised");
   a_log_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
      fault_pins.card_full ##1 fault_pins.card_full ##1 fault_pins.card_full
      |=> logging_failure_flag)
      else $error("logging flag not raised");
   a_range_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_reg.val > s_reg.rng_max |=> over_range_flag)
      else $error("over-range flag missed");
   a_span_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_reg.val < s_reg.spn_min |=> output_span_exceeded_flag)
      else $error("span flag missed");
   a_pct_full: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_reg.val >= s_reg.rng_max && s_reg.rng_max > s_reg.rng_min
      |=> percent_range == 7'h64)
      else $error("percent not full at range max");
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not cleared");
   a_e1_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(logging_failure_flag) |-> s_reg.ist[`ARC_IRQ_E1])
      else $error("logging event not latched");
   a_e2_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(sensor_wiring_fault_flag) |-> s_reg.ist[`ARC_IRQ_E2])
      else $error("wiring event not latched");
   a_e3_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(over_range_flag) |-> s_reg.ist[`ARC_IRQ_E3])
      else $error("range event not latched");
   a_e4_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(output_span_exceeded_flag) |-> s_reg.ist[`ARC_IRQ_E4])
      else $error("span event not latched");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      irq == |(s_reg.ist & s_reg.imask))
      else $error("interrupt level wrong");
   a_range_low: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_reg.val < s_reg.rng_min |=> over_range_flag)
      else $error("under-range flag missed");
   a_span_high: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_reg.val > s_reg.spn_max |=> output_span_exceeded_flag)
      else $error("span high flag missed");
   a_pct_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_reg.val <= s_reg.rng_min |=> percent_range == 7'h0)
      else $error("percent not zero at range min");
   a_pct_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
      percent_range <= 7'h64)
      else $error("percent above full scale");
endmodule

// >>> test/arc_front_model.sv
// Front end model: loads measured values and drives the fault pins.
// Assumes the bench calls its tasks from the sys_clk domain.
module arc_front_model (
   input  wire logic              sys_clk,
   output logic signed [15:0]     meas_value,
   output logic                   meas_valid,
   output arc_pkg::arc_fault_in_t fault_pins
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      meas_value = 16'sh0000;
      meas_valid = 1'b0;
      fault_pins = '0;
   end

   // Value is only qualified by the strobe; afterwards show its inverse
   task automatic send(input logic signed [15:0] v);
      @(posedge sys_clk);
      meas_value <= v;
      meas_valid <= 1'b1;
      @(posedge sys_clk);
      meas_valid <= 1'b0;
      meas_value <= ~v;
   endtask

   task automatic faults(input arc_pkg::arc_fault_in_t f);
      @(posedge sys_clk);
      fault_pins <= f;
   endtask
endmodule

// >>> test/test_alarm_relay_comparator.sv
// Self-checking bench of the alarm relay comparator with four channels.
// Assumes arc_pkg compiled first and arc_cfg.svh on the include path.
`include "arc_cfg.svh"
module test_alarm_relay_comparator;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   logic                   sys_clk;
   logic                   rstn;
   logic signed [15:0]     meas_value;
   logic                   meas_valid;
   arc_pkg::arc_fault_in_t fault_pins;
   logic [7:0]             reg_addr;
   logic [31:0]            reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [31:0]            reg_rdata;
   logic [3:0]             relay_out;
   logic [3:0]             alarm_enabled;
   logic                   log_f;
   logic                   wire_f;
   logic                   over_f;
   logic                   span_f;
   logic [6:0]             percent_range;
   logic                   irq;
   int                     n_mismatch = 0;
   int                     comparisons = 0;

   arc_top #(
      .NUM_CH(4),
      .TICK_CYC(TICK)
   ) i_dut (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .meas_value(meas_value),
      .meas_valid(meas_valid),
      .fault_pins(fault_pins),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .relay_out(relay_out),
      .alarm_enabled(alarm_enabled),
      .logging_failure_flag(log_f),
      .sensor_wiring_fault_flag(wire_f),
      .over_range_flag(over_f),
      .output_span_exceeded_flag(span_f),
      .percent_range(percent_range),
      .irq(irq)
   );

   arc_front_model i_front (
      .sys_clk(sys_clk),
      .meas_value(meas_value),
      .meas_valid(meas_valid),
      .fault_pins(fault_pins)
   );

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   task automatic setup_ch(input int n, input logic [15:0] sp, input logic [31:0] hy,
                           input logic [31:0] dl, input logic [31:0] cf);
      logic [7:0] b;
      b = 8'(`ARC_A_CH_BASE + (n << `ARC_CH_STRIDE_SH));
      wr(b, {16'h0000, sp});
      wr(b + 8'h04, hy);
      wr(b + 8'h08, dl);
      wr(b + 8'h0C, cf);
   endtask

   task automatic wait_relay(input int ch, input logic lvl);
      for (int i = 0; i < 40 && relay_out[ch] !== lvl; i++) cyc(1);
      chk(relay_out[ch], lvl);
   endtask

   task automatic t_regs();
      chk(relay_out, 4'h0);
      rd_chk(`ARC_A_CTRL, 32'h0000_0004);
      rd_chk(8'h3C, 32'h0000_0000);
      wr(`ARC_A_CHSTAT, 32'hFFFF_FFFF);
      rd_chk(`ARC_A_CHSTAT, 32'h0000_0000);
   endtask

   task automatic t_high();
      setup_ch(0, 16'd100, {16'd10, 16'd0}, 32'h0, 32'h3);
      rd_chk(`ARC_A_CH_BASE + 8'h04, 32'h000A_0000);
      i_front.send(16'sd100);
      cyc(6);
      chk(relay_out, 4'h0);
      i_front.send(16'sd101);
      cyc(6);
      chk(relay_out, 4'h1);
      rd_chk(`ARC_A_CHSTAT, 32'h0000_0101);
      i_front.send(16'sd90);
      cyc(6);
      chk(relay_out, 4'h1);
      i_front.send(16'sd89);
      cyc(6);
      chk(relay_out, 4'h0);
   endtask

   task automatic t_low();
      setup_ch(1, 16'd50, {16'd0, 16'd5}, 32'h0, 32'h1);
      i_front.send(16'sd49);
      cyc(6);
      chk(relay_out, 4'h2);
      i_front.send(16'sd55);
      cyc(6);
      chk(relay_out, 4'h2);
      i_front.send(16'sd56);
      cyc(6);
      chk(relay_out, 4'h0);
      wr(`ARC_A_CH_BASE, 32'd30);
      i_front.send(16'sd56);
      cyc(6);
      chk(relay_out, 4'h1);
      wr(`ARC_A_CH_BASE + 8'h0C, 32'h2);
      cyc(3);
      chk({alarm_enabled, relay_out}, 8'h20);
   endtask

   task automatic t_delay();
      setup_ch(2, 16'd200, 32'h0, {16'd2, 16'd3}, 32'h3);
      rd_chk(`ARC_A_CH_BASE + 8'h28, 32'h0002_0003);
      i_front.send(16'sd300);
      cyc(6);
      chk(relay_out[2], 1'b0);
      wait_relay(2, 1'b1);
      i_front.send(16'sd150);
      cyc(3);
      chk(relay_out[2], 1'b1);
      wait_relay(2, 1'b0);
      i_front.send(16'sd300);
      cyc(4);
      i_front.send(16'sd150);
      cyc(40);
      chk(relay_out[2], 1'b0);
      i_front.send(16'sd300);
      wait_relay(2, 1'b1);
      wr(`ARC_A_CH_BASE + 8'h2C, 32'h2);
      cyc(3);
      chk(relay_out, 4'h0);
   endtask

   task automatic t_flags();
      for (int i = 0; i < 6; i++) begin
         i_front.faults(6'(1 << i));
         cyc(5);
         chk({log_f, wire_f}, (i >= 3) ? 2'b10 : 2'b01);
      end
      i_front.faults('0);
      wr(`ARC_A_IRQ_MASK, 32'h4);
      i_front.send(16'sd250);
      wr(`ARC_A_IRQ_STAT, 32'h1F);
      cyc(5);
      chk({over_f, span_f, percent_range, irq}, 10'({2'b00, 7'd25, 1'b0}));
      i_front.send(16'sd1500);
      cyc(6);
      chk({over_f, span_f, irq}, 3'b111);
      rd_chk(`ARC_A_IRQ_STAT, 32'h0000_000C);
      i_front.send(16'sd600);
      cyc(6);
      chk({over_f, span_f}, 2'b01);
      i_front.send(-16'sd5);
      cyc(6);
      chk(over_f, 1'b1);
      rd_chk(`ARC_A_VALUE, 32'hFFFF_FFFB);
      rd_chk(`ARC_A_FLAGS, 32'h0000_000C);
      wr(`ARC_A_IRQ_STAT, 32'h4);
      i_front.send(16'sd1000);
      cyc(6);
      chk({percent_range, irq}, {7'd100, 1'b0});
      rd_chk(`ARC_A_PERCENT, 32'h0000_0064);
      i_front.send(16'sd0);
      cyc(6);
      chk(percent_range, 7'd0);
   endtask

   task automatic t_reset();
      chk({alarm_enabled, relay_out}, 8'h22);
      @(posedge sys_clk);
      rstn <= 1'b0;
      cyc(2);
      chk({alarm_enabled, relay_out}, 8'h00);
      @(posedge sys_clk);
      rstn <= 1'b1;
      rd_chk(`ARC_A_CH_BASE + 8'h1C, 32'h0000_0000);
   endtask

   initial begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      t_regs();
      wr(`ARC_A_RANGE_MIN, 32'h0);
      wr(`ARC_A_RANGE_MAX, 32'd1000);
      wr(`ARC_A_SPAN_MIN, 32'h0);
      wr(`ARC_A_SPAN_MAX, 32'd500);
      rd_chk(`ARC_A_RANGE_MAX, 32'h0000_03E8);
      t_high();
      t_low();
      t_delay();
      t_flags();
      t_reset();
      finish_test();
   end

   // Whole run takes a few hundred cycles; cut a hang well beyond that
   initial begin
      #800000;
      n_mismatch++;
      finish_test();
   end
endmodule
